// File: dv/gspd_driver_tb.sv
// Testbench: self test, link frames, bridge routing and PWM duty
`timescale 1ns/100ps
module gspd_driver_tb;
	import gspd_pkg::*;
	localparam int ST = 120;
	logic mclk, rst_n, external_reset_n, continuity_check_inhibit, bad_level;
	logic chip_select, serial_clock, serial_data, fault_out_n_out, fault_out_n_oe;
	logic bridge_hiz, test_switch_one, test_switch_two;
	logic [1:0] test_pair, test_level;
	wire logic [10:0] outs;
	wire logic fault_pin;
	int num_errors = 0;
	int tests_run = 0;
	int hi [11];
	int saved [11];
	int sin_at [4] = '{0, 3, 1, 2};
	int cos_at [4] = '{2, 0, 3, 1};
	// Pulled-up open-drain pin and the test comparator
	assign fault_pin = fault_out_n_oe ? fault_out_n_out : 1'b1;
	assign test_level = bad_level ? LEVEL_MID : !test_switch_two ? LEVEL_VSS :
		test_switch_one ? LEVEL_MID : LEVEL_VCC;
	gspd_host_model gspd_host_model_inst (.mclk(mclk), .chip_select(chip_select),
		.serial_clock(serial_clock), .serial_data(serial_data));
	gspd_driver #(.SELF_TEST_CYCLES(ST)) gspd_driver_inst (.mclk(mclk), .rst_n(rst_n),
		.external_reset_n(external_reset_n), .chip_select(chip_select),
		.serial_clock(serial_clock), .serial_data(serial_data), .fault_out_n_in(fault_pin),
		.fault_out_n_out(fault_out_n_out), .fault_out_n_oe(fault_out_n_oe),
		.continuity_check_inhibit(continuity_check_inhibit), .test_level(test_level),
		.bridge_hiz(bridge_hiz), .test_pair(test_pair), .test_switch_one(test_switch_one),
		.test_switch_two(test_switch_two), .gauge_a_sine_plus(outs[0]),
		.gauge_a_sine_minus(outs[1]), .gauge_a_cosine_plus(outs[2]),
		.gauge_a_cosine_minus(outs[3]), .gauge_b_sine_plus(outs[4]),
		.gauge_b_sine_minus(outs[5]), .gauge_b_cosine_plus(outs[6]),
		.gauge_b_cosine_minus(outs[7]), .small_gauge_c_drive(outs[8]),
		.small_gauge_d_drive(outs[9]), .small_gauge_e_drive(outs[10]));
	// Clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Runs past the self test, counting cycles with both switches closed
	task automatic self_test(input logic fail);
		int both;
		int last;
		both = 0;
		last = 0;
		for (int i = 0; i < ST + 30; i++) begin
			@(negedge mclk);
			if (i == ST / 2) check("fault in test", fault_out_n_oe, 1);
			if (i == ST / 2) check("hiz in test", bridge_hiz, 1);
			if (test_switch_one === 1'b1 && test_switch_two === 1'b1) both++;
			if (test_pair === PAIR_LAST) last++;
		end
		check("both closed", both, 4 * (ST / 12));
		check("last pair", last, 3 * (ST / 12));
		check("fault pin", fault_pin, !fail);
		check("fault after", fault_out_n_oe, fail);
		check("hiz after", bridge_hiz, 0);
		check("bridges idle", outs, 0);
	endtask
	// High cycles of every output over one period, after it settles
	task automatic measure();
		repeat (PWM_PERIOD + 8) @(negedge mclk);
		hi = '{default: 0};
		repeat (PWM_PERIOD) begin
			@(negedge mclk);
			for (int k = 0; k < 11; k++) if (outs[k] === 1'b1) hi[k]++;
		end
	endtask
	task automatic write(input logic [2:0] op, input logic [9:0] ang, input logic [1:0] q);
		gspd_host_model_inst.frame(op, ang, q);
		gspd_host_model_inst.deselect();
	endtask
	// Angle 0x080 gives a small sine and a large cosine
	task automatic route(input int g, input int q);
		int n;
		measure();
		for (int t = 0; t < 4; t++) begin
			n = hi[4 * g + t];
			if (t == sin_at[q]) check("sine term", n > 0 && n < 256, 1);
			else if (t == cos_at[q]) check("cosine term", n > 256, 1);
			else check("idle term", n, 0);
		end
	endtask
	// Watchdog
	initial begin
		#1000000;
		num_errors++;
		wrap_up();
	end
	initial begin
		rst_n = 1'b0;
		external_reset_n = 1'b1;
		continuity_check_inhibit = 1'b1;
		bad_level = 1'b0;
		repeat (6) @(posedge mclk);
		#1 rst_n = 1'b1;
		self_test(1'b0);
		// Small gauges take angle bits 9..1 as duty
		write(3'h4, 10'h3FF, 2'h3);
		write(3'h6, 10'h001, 2'h0);
		write(3'h5, 10'h0AB, 2'h1);
		measure();
		check("duty c", hi[8], 511);
		check("duty d", hi[9], 0);
		check("duty e", hi[10], 85);
		// Every quadrant in turn, wrapping back to the first
		for (int g = 0; g < 2; g++) begin
			for (int q = 0; q < 5; q++) begin
				gspd_host_model_inst.frame(g ? 3'h3 : 3'h1, 10'h080, 2'(q));
				check("no step fault", fault_out_n_oe, 0);
				gspd_host_model_inst.deselect();
				route(g, q % 4);
			end
		end
		// Reserved codes change nothing
		saved = hi;
		write(3'h0, 10'h3C3, 2'h2);
		write(3'h2, 10'h3C3, 2'h2);
		write(3'h7, 10'h3C3, 2'h2);
		measure();
		for (int k = 0; k < 11; k++) check("reserved", hi[k], saved[k]);
		// Jump of two quadrants is flagged and not stored
		gspd_host_model_inst.frame(3'h1, 10'h080, 2'h2);
		check("step fault", fault_out_n_oe, 1);
		repeat (10) @(posedge mclk);
		check("fault held", fault_out_n_oe, 1);
		gspd_host_model_inst.deselect();
		check("fault released", fault_out_n_oe, 0);
		route(0, 0);
		// Resend under the same select after an error
		gspd_host_model_inst.frame(3'h1, 10'h080, 2'h2);
		gspd_host_model_inst.frame(3'h1, 10'h080, 2'h1);
		check("resend ok", fault_out_n_oe, 0);
		gspd_host_model_inst.deselect();
		route(0, 1);
		// Inhibit at ground stores despite the error
		@(posedge mclk);
		#1 continuity_check_inhibit = 1'b0;
		gspd_host_model_inst.frame(3'h1, 10'h080, 2'h3);
		check("inhibit fault", fault_out_n_oe, 1);
		gspd_host_model_inst.deselect();
		route(0, 3);
		// External reset restarts the test, which now fails
		@(posedge mclk);
		#1 external_reset_n = 1'b0;
		continuity_check_inhibit = 1'b1;
		bad_level = 1'b1;
		repeat (3) @(posedge mclk);
		#1 external_reset_n = 1'b1;
		self_test(1'b1);
		wrap_up();
	end
endmodule

// File: dv/gspd_host_model.sv
// Partner: processor side of the three-wire serial link
`timescale 1ns/100ps
module gspd_host_model (
	// Clock
	input wire logic mclk,
	// Serial link
	output logic chip_select,
	output logic serial_clock,
	output logic serial_data
);
	// Link idles deselected with the clock standing low
	initial begin
		chip_select = 1'b0;
		serial_clock = 1'b0;
		serial_data = 1'b0;
	end
	// One bit: data settles while low, held across the rise
	task automatic put_bit(input logic b);
		@(posedge mclk);
		#1 serial_data = b;
		repeat (4) @(posedge mclk);
		#1 serial_clock = 1'b1;
		repeat (4) @(posedge mclk);
		#1 serial_clock = 1'b0;
	endtask
	// Stray zero, start bit 1, then 15 bits MSB first
	task automatic frame(input logic [2:0] op, input logic [9:0] ang, input logic [1:0] quad);
		logic [15:0] word;
		word = {1'b1, op, ang, quad};
		@(posedge mclk);
		#1 chip_select = 1'b1;
		repeat (3) @(posedge mclk);
		put_bit(1'b0);
		for (int i = 15; i >= 0; i--) put_bit(word[i]);
		serial_data = ~serial_data;
		repeat (6) @(posedge mclk);
	endtask
	// Drop select; data no longer holds its value
	task automatic deselect();
		@(posedge mclk);
		#1 chip_select = 1'b0;
		serial_data = ~serial_data;
		repeat (8) @(posedge mclk);
	endtask
endmodule

// File: logic/gspd_driver.sv
// Top: serial link, self test, gauge registers and bridge routing
`timescale 1ns/100ps
module gspd_driver #(
	parameter int SELF_TEST_CYCLES = gspd_pkg::SELF_TEST_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic external_reset_n,
	// Serial link
	input wire logic chip_select,
	input wire logic serial_clock,
	input wire logic serial_data,
	// Open-drain fault pin
	input wire logic fault_out_n_in,
	output logic fault_out_n_out,
	output logic fault_out_n_oe,
	// Configuration
	input wire logic continuity_check_inhibit,
	// Self test front end
	input wire logic [1:0] test_level,
	output logic bridge_hiz,
	output logic [1:0] test_pair,
	output logic test_switch_one,
	output logic test_switch_two,
	// First 360-degree bridge
	output logic gauge_a_sine_plus,
	output logic gauge_a_sine_minus,
	output logic gauge_a_cosine_plus,
	output logic gauge_a_cosine_minus,
	// Second 360-degree bridge
	output logic gauge_b_sine_plus,
	output logic gauge_b_sine_minus,
	output logic gauge_b_cosine_plus,
	output logic gauge_b_cosine_minus,
	// 90-degree outputs
	output logic small_gauge_c_drive,
	output logic small_gauge_d_drive,
	output logic small_gauge_e_drive
);
	import gspd_pkg::*;

	// ---------------------------------------------------------------
	// Constants and state
	// ---------------------------------------------------------------
	localparam int STEP_RAW = SELF_TEST_CYCLES / TEST_STEPS;
	localparam int STEP_CYCLES = (STEP_RAW > 0) ? STEP_RAW : 1;
	localparam int STEP_W = $clog2(STEP_CYCLES + 1);

	logic sclk_q;
	logic cs_q;

	gspd_test_t test_state;
	logic [STEP_W-1:0] step_cnt;
	logic [1:0] test_step;
	logic test_fail;

	gspd_link_t link_state;
	logic [3:0] bit_cnt;
	logic [FRAME_BITS-1:0] shreg;
	logic frame_ready;
	logic err_result;
	logic err_armed;
	logic drive_err;

	logic [9:0] big_angle [BIG_GAUGES];
	logic [1:0] big_quad [BIG_GAUGES];
	logic [BIG_GAUGES-1:0] big_loaded;
	logic [8:0] small_duty [SMALL_GAUGES];
	logic [8:0] sine_duty [BIG_GAUGES];
	logic [8:0] cosine_duty [BIG_GAUGES];
	logic [BIG_GAUGES-1:0] sine_duty_wave;
	logic [BIG_GAUGES-1:0] cosine_duty_wave;

	gspd_duty_if #(.CHANNELS(PWM_CHANNELS)) duty_bus ();

	// ---------------------------------------------------------------
	// Decoding functions
	// ---------------------------------------------------------------
	// One-hot gauge select, all zero for reserved codes
	function automatic logic [GAUGES-1:0] gauge_hit(input logic [2:0] op);
		gauge_hit = '0;
		for (int g = 0; g < GAUGES; g++) begin
			if (op == OP_CODE[g]) begin
				gauge_hit[g] = 1'b1; // [R9]
			end
		end
	endfunction

	// Equal or one step away, wrapping between fourth and first
	function automatic logic quad_ok(input logic [1:0] prev, input logic [1:0] quad);
		logic [1:0] up;
		logic [1:0] down;
		up = prev + 2'h1;
		down = prev - 2'h1;
		quad_ok = (quad == prev) || (quad == up) || (quad == down); // [R23]
	endfunction

	// Terminal pattern {sine+, sine-, cosine+, cosine-} per quadrant
	function automatic logic [3:0] route(input logic [1:0] q, input logic s, input logic c);
		unique case (q)
			2'h0: route = {s, 1'b0, c, 1'b0}; // [R19] [R20]
			2'h1: route = {c, 1'b0, 1'b0, s};
			2'h2: route = {1'b0, s, 1'b0, c};
			2'h3: route = {1'b0, c, s, 1'b0};
		endcase
	endfunction

	// ---------------------------------------------------------------
	// Edge detection and decode
	// ---------------------------------------------------------------
	// Link pins are synchronous; edges come from one stored sample
	wire restart = !external_reset_n;
	wire sclk_rise = serial_clock && !sclk_q;
	wire sclk_fall = !serial_clock && sclk_q;
	wire cs_fall = !chip_select && cs_q;

	// Self test sequencing
	wire testing = test_state == GSPD_TEST_RUN;
	wire step_end = testing && (step_cnt == STEP_W'(STEP_CYCLES - 1));
	wire step_last = test_step == STEP_S2_ONLY;
	wire test_last = step_end && step_last && (test_pair == PAIR_LAST);
	wire [1:0] next_step = step_last ? STEP_S1_ONLY : test_step + 2'h1;
	wire [1:0] expect_level = (test_step == STEP_S1_ONLY) ? LEVEL_VSS :
		(test_step == STEP_BOTH) ? LEVEL_MID : LEVEL_VCC;

	// Frame fields
	wire [FRAME_BITS-1:0] next_shreg = {shreg[FRAME_BITS-2:0], serial_data};
	wire start_seen = (link_state == GSPD_LINK_HUNT) && sclk_rise && serial_data;
	wire shifting = (link_state == GSPD_LINK_SHIFT) && sclk_rise;
	wire frame_end = shifting && (bit_cnt == LAST_BIT);
	wire [GAUGES-1:0] next_hit = gauge_hit(next_shreg[OP_MSB -: 3]);
	wire [GAUGES-1:0] hit = gauge_hit(shreg[OP_MSB -: 3]);
	wire [9:0] frame_angle = shreg[ANG_MSB -: 10]; // [R11]
	wire [1:0] frame_quad = shreg[QUAD_MSB -: 2]; // [R12]

	// Continuity against the last stored quadrant of the target
	wire jump_a = big_loaded[0] && !quad_ok(big_quad[0], next_shreg[QUAD_MSB -: 2]);
	wire jump_b = big_loaded[1] && !quad_ok(big_quad[1], next_shreg[QUAD_MSB -: 2]);
	wire next_err = (next_hit[0] && jump_a) || (next_hit[1] && jump_b); // [R13]

	// Store on chip select fall: write code, and no error unless inhibited
	wire err_blocks = err_result && continuity_check_inhibit; // [R17]
	wire commit = cs_fall && frame_ready && (|hit) && !err_blocks; // [R16] [R10]

	// ---------------------------------------------------------------
	// Self test
	// ---------------------------------------------------------------
	// Twelve equal steps: four bridge pairs, three switch settings each
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			test_state <= GSPD_TEST_RUN;
			step_cnt <= '0;
			test_step <= STEP_S1_ONLY;
			test_pair <= PAIR_FIRST;
			test_fail <= 1'b0;
			bridge_hiz <= 1'b1;
			test_switch_one <= 1'b1;
			test_switch_two <= 1'b0;
		end else if (restart) begin
			test_state <= GSPD_TEST_RUN;
			step_cnt <= '0;
			test_step <= STEP_S1_ONLY;
			test_pair <= PAIR_FIRST;
			test_fail <= 1'b0;
			bridge_hiz <= 1'b1; // [R1]
			test_switch_one <= 1'b1;
			test_switch_two <= 1'b0;
		end else if (testing) begin
			step_cnt <= step_end ? '0 : step_cnt + STEP_W'(1); // [R4]
			if (step_end) begin
				test_fail <= test_fail || (test_level != expect_level); // [R2]
				test_step <= next_step;
				test_switch_one <= next_step != STEP_S2_ONLY; // [R2]
				test_switch_two <= next_step != STEP_S1_ONLY;
				if (step_last) begin
					test_pair <= test_pair + 2'h1; // [R1]
				end
			end
			if (test_last) begin
				test_state <= GSPD_TEST_DONE;
				bridge_hiz <= 1'b0;
				test_switch_one <= 1'b0;
				test_switch_two <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Serial link
	// ---------------------------------------------------------------
	// Pin samples for edge detection
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_q <= 1'b0;
			cs_q <= 1'b0;
		end else begin
			sclk_q <= serial_clock;
			cs_q <= chip_select;
		end
	end

	// Frame receiver: hunt for start bit, shift fifteen bits
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			link_state <= GSPD_LINK_IDLE;
			bit_cnt <= 4'h0;
			shreg <= '0;
		end else if (!chip_select) begin
			link_state <= GSPD_LINK_IDLE; // [R8]
		end else begin
			unique case (link_state)
				GSPD_LINK_IDLE: begin
					link_state <= GSPD_LINK_HUNT;
				end
				GSPD_LINK_HUNT: begin
					if (start_seen) begin
						link_state <= GSPD_LINK_SHIFT; // [R8] [R15]
						bit_cnt <= 4'h0;
					end
				end
				GSPD_LINK_SHIFT: begin
					if (shifting) begin
						shreg <= next_shreg; // [R6]
						bit_cnt <= bit_cnt + 4'h1;
					end
					if (frame_end) begin
						link_state <= GSPD_LINK_HUNT; // [R15]
					end
				end
				default: begin
					link_state <= GSPD_LINK_IDLE;
				end
			endcase
		end
	end

	// Frame result and error status
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			frame_ready <= 1'b0;
			err_result <= 1'b0;
			err_armed <= 1'b0;
			drive_err <= 1'b0;
		end else if (!chip_select) begin
			frame_ready <= 1'b0;
			err_result <= 1'b0;
			err_armed <= 1'b0;
			drive_err <= 1'b0; // [R14]
		end else begin
			if (start_seen) begin
				frame_ready <= 1'b0;
			end
			if (frame_end) begin
				frame_ready <= 1'b1;
				err_result <= next_err; // [R13]
				err_armed <= 1'b1;
			end else if (sclk_fall && err_armed) begin
				drive_err <= err_result; // [R7]
				err_armed <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Gauge registers
	// ---------------------------------------------------------------
	// Angle and quadrant per big gauge, duty per small gauge
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			big_loaded <= '0;
			for (int g = 0; g < BIG_GAUGES; g++) begin
				big_angle[g] <= ANGLE_RESET;
				big_quad[g] <= QUAD_RESET;
			end
			for (int k = 0; k < SMALL_GAUGES; k++) begin
				small_duty[k] <= DUTY_RESET;
			end
		end else if (restart) begin
			big_loaded <= '0;
			for (int k = 0; k < SMALL_GAUGES; k++) begin
				small_duty[k] <= DUTY_RESET;
			end
		end else if (commit) begin
			for (int g = 0; g < BIG_GAUGES; g++) begin
				if (hit[g]) begin
					big_angle[g] <= frame_angle; // [R16]
					big_quad[g] <= frame_quad;
					big_loaded[g] <= 1'b1;
				end
			end
			for (int k = 0; k < SMALL_GAUGES; k++) begin
				if (hit[BIG_GAUGES + k]) begin
					small_duty[k] <= frame_angle[9:1]; // [R22]
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Duty lookup and PWM
	// ---------------------------------------------------------------
	// Table lookup per big gauge; cosine reads the mirrored address
	generate
		for (genvar g = 0; g < BIG_GAUGES; g++) begin : g_big
			gspd_sine_rom u_rom (
				.mclk(mclk),
				.rst_n(rst_n),
				.sine_addr(big_angle[g][9:1]), // [R18]
				.cosine_addr(~big_angle[g][9:1]),
				.sine_data(sine_duty[g]),
				.cosine_data(cosine_duty[g])
			);
			assign duty_bus.duty[2 * g] = sine_duty[g];
			assign duty_bus.duty[2 * g + 1] = cosine_duty[g];
			assign sine_duty_wave[g] = duty_bus.wave[2 * g];
			assign cosine_duty_wave[g] = duty_bus.wave[2 * g + 1];
		end
		for (genvar k = 0; k < SMALL_GAUGES; k++) begin : g_small
			assign duty_bus.duty[2 * BIG_GAUGES + k] = small_duty[k];
		end
	endgenerate

	gspd_pwm_bank #(.CHANNELS(PWM_CHANNELS)) u_pwm (
		.mclk(mclk),
		.rst_n(rst_n),
		.duty_bus(duty_bus)
	);

	// ---------------------------------------------------------------
	// Output stage
	// ---------------------------------------------------------------
	// Bridges held at VSS during test and until a gauge is loaded
	wire [3:0] route_a = route(big_quad[0], sine_duty_wave[0], cosine_duty_wave[0]);
	wire [3:0] route_b = route(big_quad[1], sine_duty_wave[1], cosine_duty_wave[1]);
	wire [1:0] bridge_on = big_loaded & {2{!bridge_hiz}};
	wire fault_low = testing || test_fail || drive_err;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			{gauge_a_sine_plus, gauge_a_sine_minus} <= 2'h0;
			{gauge_a_cosine_plus, gauge_a_cosine_minus} <= 2'h0;
			{gauge_b_sine_plus, gauge_b_sine_minus} <= 2'h0;
			{gauge_b_cosine_plus, gauge_b_cosine_minus} <= 2'h0;
			{small_gauge_e_drive, small_gauge_d_drive, small_gauge_c_drive} <= 3'h0;
			fault_out_n_out <= 1'b0;
			fault_out_n_oe <= 1'b1;
		end else begin
			{gauge_a_sine_plus, gauge_a_sine_minus, gauge_a_cosine_plus,
				gauge_a_cosine_minus} <= bridge_on[0] ? route_a : 4'h0; // [R5] [R20]
			{gauge_b_sine_plus, gauge_b_sine_minus, gauge_b_cosine_plus,
				gauge_b_cosine_minus} <= bridge_on[1] ? route_b : 4'h0; // [R21]
			{small_gauge_e_drive, small_gauge_d_drive,
				small_gauge_c_drive} <= duty_bus.wave[6:4]; // [R22]
			fault_out_n_out <= 1'b0;
			fault_out_n_oe <= fault_low; // [R3] [R14]
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	// Cycles spent in the self test since the last start
	logic [31:0] run_cycles;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			run_cycles <= 32'h0;
		end else if (restart) begin
			run_cycles <= 32'h0;
		end else if (testing) begin
			run_cycles <= run_cycles + 32'h1;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n || !external_reset_n);

	fault_test_a: assert property (testing |=> fault_out_n_oe) // [R3]
		else $error("fault pin released during self test");
	test_length_a: assert property ($fell(testing) |-> // [R4]
		run_cycles == 32'(STEP_CYCLES * TEST_STEPS))
		else $error("self test length wrong");
	bridge_idle_a: assert property (!bridge_on[0] |=> // [R5]
		!gauge_a_sine_plus && !gauge_a_sine_minus && !gauge_a_cosine_plus && !gauge_a_cosine_minus)
		else $error("bridge driven before a gauge was loaded");
	fault_edge_a: assert property (sclk_fall && err_armed && err_result && chip_select // [R7]
		|-> ##2 fault_out_n_oe)
		else $error("error status not shown at serial clock fall");
	link_idle_a: assert property (!chip_select |=> link_state == GSPD_LINK_IDLE) // [R8]
		else $error("link active with chip select low");
	reserved_op_a: assert property (cs_fall && !(|hit) |=> // [R10]
		$stable(big_angle[0]) && $stable(big_angle[1]) && $stable(small_duty[0]))
		else $error("reserved code changed a gauge");
	fault_release_a: assert property (cs_fall && !testing && !test_fail // [R14]
		|-> ##2 !fault_out_n_oe)
		else $error("fault pin held after chip select fall");
	start_bit_a: assert property (start_seen && chip_select |=> // [R15]
		link_state == GSPD_LINK_SHIFT && bit_cnt == 4'h0)
		else $error("start bit not taken");
	commit_store_a: assert property (commit && hit[0] |=> // [R16]
		big_angle[0] == $past(frame_angle) && big_loaded[0])
		else $error("gauge one not stored on commit");
	error_block_a: assert property (cs_fall && err_result && continuity_check_inhibit // [R16]
		|=> $stable(big_quad[0]) && $stable(big_quad[1]))
		else $error("frame with quadrant error was stored");
endmodule

// File: logic/gspd_duty_if.sv
// Interface: duty values towards the PWM bank and waves back
`timescale 1ns/100ps
interface gspd_duty_if #(
	parameter int CHANNELS = gspd_pkg::PWM_CHANNELS
);
	logic [gspd_pkg::PWM_BITS-1:0] duty [CHANNELS];
	logic [CHANNELS-1:0] wave;
	modport ctrl (output duty, input wave);
	modport gen (input duty, output wave);
endinterface

// File: logic/gspd_pkg.sv
// Package: shared constants and types of the cross-coil gauge driver
//
// Contract
// R1 - After reset, test each 360-degree bridge pair with buffers high-impedance.
// R2 - Three test steps: first switch expects VSS, both half supply, second supply.
// R3 - Fault output low during test; afterwards low on failure, else released.
// R4 - Whole self test is a fixed cycle count, about 4 ms.
// R5 - After the test bridges sit at VSS until an angle is delivered.
// R6 - Serial data is sampled on the rising serial clock edge.
// R7 - Error status appears at the serial clock fall after the last bit.
// R8 - Chip select low ignores the link; high waits for start bit 1, then 15 bits.
// R9 - Codes 001, 011, 100, 110, 101 select gauges one to five.
// R10 - Any other code changes no stored value and no output.
// R11 - Ten bits after the code are the angle, MSB first.
// R12 - Last two bits are the quadrant, MSB first, for gauges one and two.
// R13 - A quadrant not continuous with the previous one pulls the fault output low.
// R14 - Error holds while chip select is high; chip select fall releases it. The code also releases it after a later frame without error.
// R15 - After an error, the next 1 bit starts a fresh 15-bit frame.
// R16 - Chip select fall stores a write frame only when no quadrant error occurred.
// R17 - Inhibit pin at ground stores every write frame despite quadrant errors.
// R18 - Sine and cosine duty come from a 512 by 9 table; angle LSB ignored.
// R19 - Quadrant codes 00 to 11 select the four 90-degree ranges.
// R20 - Each quadrant routes sine and cosine to fixed terminals; others held 0.
// R21 - PWM period is 512 clock cycles; gauge two has its own bridges.
// R22 - Small gauges take the top nine angle bits as duty directly.
// R23 - Quadrant is continuous when equal or one step away, wrapping around.
// R24 - Duty is the count of high cycles per period; zero stays low.
package gspd_pkg;
	// Self test timing, counted in cycles of an 8 MHz oscillator
	localparam int CLK_MHZ = 8;
	localparam int SELF_TEST_US = 4000;
	localparam int SELF_TEST_CYCLES = SELF_TEST_US * CLK_MHZ;
	localparam int TEST_STEPS = 12;
	// PWM
	localparam int PWM_BITS = 9;
	localparam int PWM_PERIOD = 512;
	localparam int PWM_CHANNELS = 7;
	localparam logic [8:0] PHASE_RESET = 9'h000;
	// Gauges and operation codes
	localparam int GAUGES = 5;
	localparam int BIG_GAUGES = 2;
	localparam int SMALL_GAUGES = 3;
	localparam logic [2:0] OP_CODE [GAUGES] = '{3'h1, 3'h3, 3'h4, 3'h6, 3'h5};
	// Frame layout after the start bit
	localparam int FRAME_BITS = 15;
	localparam logic [3:0] LAST_BIT = 4'hE;
	localparam int OP_MSB = 14;
	localparam int ANG_MSB = 11;
	localparam int QUAD_MSB = 1;
	// Reset values
	localparam logic [9:0] ANGLE_RESET = 10'h000;
	localparam logic [1:0] QUAD_RESET = 2'h0;
	localparam logic [8:0] DUTY_RESET = 9'h000;
	// Self test steps and expected levels
	localparam logic [1:0] STEP_S1_ONLY = 2'h0;
	localparam logic [1:0] STEP_BOTH = 2'h1;
	localparam logic [1:0] STEP_S2_ONLY = 2'h2;
	localparam logic [1:0] PAIR_FIRST = 2'h0;
	localparam logic [1:0] PAIR_LAST = 2'h3;
	localparam logic [1:0] LEVEL_VSS = 2'h0;
	localparam logic [1:0] LEVEL_MID = 2'h1;
	localparam logic [1:0] LEVEL_VCC = 2'h2;
	typedef enum logic [1:0] {GSPD_LINK_IDLE, GSPD_LINK_HUNT, GSPD_LINK_SHIFT} gspd_link_t;
	typedef enum logic {GSPD_TEST_RUN, GSPD_TEST_DONE} gspd_test_t;
endpackage

// File: logic/gspd_pwm_bank.sv
// PWM bank: one period counter and a comparator per channel
`timescale 1ns/100ps
module gspd_pwm_bank #(
	parameter int CHANNELS = gspd_pkg::PWM_CHANNELS
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Duty values and waves
	gspd_duty_if.gen duty_bus
);
	import gspd_pkg::*;
	logic [PWM_BITS-1:0] phase;
	logic [CHANNELS-1:0] wave_q;
	wire [CHANNELS-1:0] high_now;

	// Period counter wraps every 512 cycles
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= PHASE_RESET;
			wave_q <= '0;
		end else begin
			phase <= phase + PWM_BITS'(1); // [R21]
			wave_q <= high_now;
		end
	end

	// High while the phase is below the duty
	generate
		for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_cmp
			assign high_now[ch] = phase < duty_bus.duty[ch]; // [R24]
		end
	endgenerate
	assign duty_bus.wave = wave_q;

	period_wrap_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R21]
		phase == PWM_BITS'(PWM_PERIOD - 1) |=> phase == PHASE_RESET)
		else $error("PWM period counter did not wrap");
	zero_duty_a: assert property (@(posedge mclk) disable iff (!rst_n) // [R24]
		$past(duty_bus.duty[0]) == DUTY_RESET |-> !wave_q[0])
		else $error("zero duty produced a high wave");
endmodule

// File: logic/gspd_sine_rom.sv
// Memory: quarter-wave sine table, 512 by 9, two registered read ports
`timescale 1ns/100ps
module gspd_sine_rom (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Read ports
	input wire logic [8:0] sine_addr,
	input wire logic [8:0] cosine_addr,
	output logic [8:0] sine_data,
	output logic [8:0] cosine_data
);
	import gspd_pkg::*;
	localparam int SPAN = 1024;
	localparam int DENOM = 1310720;
	localparam int FULL = 511;

	// Rational sine approximation over 0 to 89.8 degrees, scaled to 511
	function automatic logic [8:0] sine_entry(input logic [8:0] a);
		int p;
		p = int'(a) * (SPAN - int'(a));
		sine_entry = 9'((4 * p * FULL) / (DENOM - p));
	endfunction

	// Registered read data
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sine_data <= DUTY_RESET;
			cosine_data <= DUTY_RESET;
		end else begin
			sine_data <= sine_entry(sine_addr); // [R18]
			cosine_data <= sine_entry(cosine_addr);
		end
	end
endmodule
